// [dv/epiu_ext_pin_interrupt_unit_props.sv]
// port checker for the external pin interrupt unit
`timescale 1ns/1ps
module epiu_ext_pin_interrupt_unit_props import epiu_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic vectorAck,
  input wire logic [2:0] vectorNum,
  input wire logic irq
);
  // copy of written settings; flag places in it mean nothing
  logic [7:0] sh [0:15];
  always_ff @(posedge ref_clk)
    if (!nrst) sh <= '{default: 8'h00};
    else if (regWrite) sh[regAddr] <= regWrData;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_rsv_bits_zero: assert property (regRead && regAddr inside {[1:4]} |=> regRdData[7:2] == 6'h00)
    else $error("reserved bits set");
  a_vec_in_range: assert property (vectorNum <= VEC_GROUP_HI) else $error("bad vector");
  a_ack_clears_vec: assert property (vectorAck && vectorNum != VEC_NONE |=> vectorNum == VEC_NONE)
    else $error("vector kept after entry");
  // a setting that just dropped may still own the vector for one cycle
  a_vec_needs_gie: assert property (vectorNum != VEC_NONE |-> sh[7][7] || $past(sh[7][7]))
    else $error("vector without global enable");
  a_pin_needs_en: assert property (vectorNum == VEC_PIN_ZERO |-> sh[1][0] || $past(sh[1][0]))
    else $error("pin vector while disabled");
  a_grp_needs_en: assert property (vectorNum == VEC_GROUP_HI |-> sh[3][1] || $past(sh[3][1]))
    else $error("group vector while disabled");
  a_level_flag_low: assert property (
    regRead && regAddr == ADDR_EXT_FLAGS && sh[0][1:0] == 2'h0 && $past(sh[0][1:0]) == 2'h0
    |=> !regRdData[0]) else $error("flag set in level mode");
  a_irq_needs_mask: assert property (irq |-> sh[9][3:0] != 4'h0) else $error("irq while masked");
endmodule
bind epiu_ext_pin_interrupt_unit epiu_ext_pin_interrupt_unit_props u_props (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRdData(regRdData),
  .vectorAck(vectorAck),
  .vectorNum(vectorNum),
  .irq(irq)
);

// [dv/epiu_partner.sv]
// partner model: pin drivers and the core taking vectors
`timescale 1ns/1ps
module epiu_partner (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [17:0] drive,
  input wire logic [7:0] ackDelay,
  input wire logic vectorReq,
  output logic [1:0] extPins,
  output logic [7:0] change_inputs_hi,
  output logic [7:0] change_inputs_lo,
  output logic vectorAck
);
  int waitCnt = 0;
  initial {extPins, change_inputs_hi, change_inputs_lo, vectorAck} = 19'h00000;
  // pins move on edges only, so each level lasts a full cycle
  always @(posedge ref_clk) {extPins, change_inputs_hi, change_inputs_lo} <= drive;
  // delay FF: core never enters, so requests stay pending
  always @(posedge ref_clk) begin
    vectorAck <= nrst && vectorReq && !vectorAck && ackDelay != 8'hFF && waitCnt >= ackDelay;
    waitCnt <= (!nrst || !vectorReq || vectorAck) ? 0 : waitCnt + 1;
  end
endmodule

// [dv/tb_ext_pin_interrupt_unit.sv]
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
module tb_ext_pin_interrupt_unit import epiu_pkg::*;;
  logic ref_clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0, vectorAck, vectorReq, irq;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, ackDelay = 8'hFF, mHi, mLo, regRdData, change_inputs_hi, change_inputs_lo;
  logic [1:0] extPins;
  logic [2:0] vectorNum;
  logic [2:0] expQ[$];
  logic [17:0] drive = 18'h00000;
  int error_cnt = 0, checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  epiu_ext_pin_interrupt_unit u_epiu_ext_pin_interrupt_unit (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .extPins(extPins),
    .change_inputs_hi(change_inputs_hi),
    .change_inputs_lo(change_inputs_lo),
    .vectorAck(vectorAck),
    .vectorReq(vectorReq),
    .vectorNum(vectorNum),
    .irq(irq)
  );
  epiu_partner u_epiu_partner (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .drive(drive),
    .ackDelay(ackDelay),
    .vectorReq(vectorReq),
    .extPins(extPins),
    .change_inputs_hi(change_inputs_hi),
    .change_inputs_lo(change_inputs_lo),
    .vectorAck(vectorAck)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  // six cycles cover the two-flop synchroniser and the flag stage
  task automatic pins(input logic [17:0] d);
    @(posedge ref_clk);
    drive <= d;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic take(input logic [2:0] exp);
    int n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (vectorAck !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    if (n >= 50) close_out();
    chk(8'(vectorNum), 8'(exp));
  endtask
  initial begin
    void'($urandom(32'h840E));
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    // both pins idle low in level mode after reset, so their status bits are already set
    for (int a = 0; a < 16; a++) rd(4'(a), (a == ADDR_IRQ_STAT) ? 8'h03 : 8'h00);
    wr(ADDR_EXT_EN, 8'hFF);
    wr(ADDR_GRP_EN, 8'hFF);
    rd(ADDR_EXT_EN, 8'h03);
    rd(ADDR_GRP_EN, 8'h03);
    mHi = 8'($urandom) & 8'h7F | 8'h01;
    mLo = 8'($urandom) | 8'h80;
    wr(ADDR_MASK_HI, mHi);
    wr(ADDR_MASK_LO, mLo);
    rd(ADDR_MASK_HI, mHi);
    rd(ADDR_MASK_LO, mLo);
    wr(ADDR_CORE, 8'h80);
    $display("registers done");
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(ADDR_SENSE, 8'((c << (2 * p)) | (3 << (2 - 2 * p))));
        wr(ADDR_EXT_FLAGS, 8'h03);
        pins(drive | (18'h10000 << p));
        rd(ADDR_EXT_FLAGS, 8'(c == 1 || c == 3) << p);
        wr(ADDR_EXT_FLAGS, 8'h03);
        rd(ADDR_EXT_FLAGS, 8'h00);
        pins(drive & ~(18'h10000 << p));
        rd(ADDR_EXT_FLAGS, 8'(c == 1 || c == 2) << p);
        chk(8'(vectorNum), 8'(c == 3 ? VEC_NONE : p ? VEC_PIN_ONE : VEC_PIN_ZERO));
      end
    end
    $display("sense done");
    wr(ADDR_SENSE, 8'h0F);
    wr(ADDR_EXT_FLAGS, 8'h03);
    wr(ADDR_CORE, 8'h00);
    ackDelay <= 8'h03;
    pins(drive ^ 18'(mLo));
    #1 chk(8'(vectorReq), 8'h00);
    rd(ADDR_GRP_FLAGS, 8'h01);
    pins(drive ^ {2'h0, ~mHi, 8'h00});
    rd(ADDR_GRP_FLAGS, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h0F);
    #1 chk(8'(irq), 8'h01);
    wr(ADDR_IRQ_STAT, 8'h0F);
    #1 chk(8'(irq), 8'h00);
    pins(drive ^ {2'h1, mHi, 8'h00});
    wr(ADDR_CORE, 8'h80);
    expQ = '{VEC_PIN_ZERO, VEC_GROUP_LO, VEC_GROUP_HI};
    repeat (3) take(expQ.pop_front());
    rd(ADDR_EXT_FLAGS, 8'h00);
    rd(ADDR_GRP_FLAGS, 8'h00);
    $display("dispatch done");
    close_out();
  end
endmodule

// [hdl/epiu_ext_pin_interrupt_unit.sv]
// external pin and pin change interrupt unit with register port and vector dispatch
// Contract
// R1: a dedicated pin interrupts the core only when its enable bit and the global enable are both one.
// R2: pin activity raises requests whatever the pin direction, since the input is sampled always.
// R3: sense code 00 is low level, 01 any change, 10 falling edge, 11 rising edge.
// R4: the driver of a dedicated pin holds each pulse longer than one clock period.
// R5: a dedicated pin flag is set when an edge or change on its pin triggers.
// R6: a dedicated pin flag stays zero in level mode and the low level is presented directly.
// R7: a set flag with its enable and the global enable asks the core to jump to its vector.
// R8: every flag is cleared when the core enters the matching interrupt routine.
// R9: writing one to a flag bit clears it and writing zero leaves it.
// R10: the two pins and the two change groups each have their own vector.
// R11: each change group interrupts on any change of an enabled input with group and global enable.
// R12: a change group flag is set when any enabled input of its group changes.
// R13: a change mask bit enables its input in its group and a cleared bit excludes it.
// R14: bits 7 down to 2 of the enable and flag registers read as zero.
// R15: pin inputs are synchronised before comparison so each change sets a flag once.
`timescale 1ns/1ps
module epiu_ext_pin_interrupt_unit
  import epiu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic [1:0] extPins,
  input wire logic [7:0] change_inputs_hi,
  input wire logic [7:0] change_inputs_lo,
  input wire logic vectorAck,
  output logic vectorReq,
  output logic [2:0] vectorNum,
  output logic irq
);
  logic [1:0] extSync1;
  logic [1:0] extSync2;
  logic [1:0] extPrev;
  logic [15:0] chgSync1;
  logic [15:0] chgSync2;
  logic [15:0] chgPrev;
  logic primed;
  logic [2:0] primeDly;
  logic [3:0] sense_control_reg;
  logic [1:0] ext_irq_enable;
  logic [1:0] ext_irq_flags;
  logic [1:0] change_group_enable;
  logic [1:0] change_group_flags;
  logic [7:0] change_mask_high;
  logic [7:0] change_mask_low;
  logic globalEnable;
  logic [3:0] irqStatus;
  logic [3:0] irqMask;
  logic [1:0] extTrig;
  logic [1:0] extLevel;
  logic [1:0] grpTrig;
  logic [1:0] extPend;
  logic [1:0] grpPend;
  logic [1:0] extClrW;
  logic [1:0] grpClrW;
  logic [1:0] extClrV;
  logic [1:0] grpClrV;
  logic [1:0] extLevelMode;
  logic [2:0] next_vectorNum;
  logic [15:0] chgNow;
  logic [15:0] chgPast;
  logic [15:0] chgMask;

  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      extSync1 <= 2'h0;
      extSync2 <= 2'h0;
      chgSync1 <= 16'h0000;
      chgSync2 <= 16'h0000;
    end else begin
      extSync1 <= extPins; // R2
      extSync2 <= extSync1; // R15
      chgSync1 <= {change_inputs_hi, change_inputs_lo};
      chgSync2 <= chgSync1; // R15
    end
  end

  // previous samples; a real pin value reaches this stage only three edges after release,
  // so a pin idling high must not look like an edge before then
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      extPrev <= 2'h0;
      chgPrev <= 16'h0000;
      primeDly <= 3'h0;
    end else begin
      extPrev <= extSync2;
      chgPrev <= chgSync2;
      primeDly <= {primeDly[1:0], 1'b1};
    end
  end

  assign primed = primeDly[2]; // R15

  assign chgNow = chgSync2;
  assign chgPast = chgPrev;
  assign chgMask = {change_mask_high, change_mask_low};

  // per-pin trigger decode
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ext
      logic [1:0] mode;
      assign mode = (gi == 0) ? sense_control_reg[SENSE_ZERO_POS +: 2] : sense_control_reg[SENSE_ONE_POS +: 2];
      assign extLevelMode[gi] = (mode == SENSE_LOW); // R6
      assign extLevel[gi] = extLevelMode[gi] && !extSync2[gi]; // R6
      always_comb begin
        unique case (mode) // R3
          SENSE_LOW: extTrig[gi] = 1'b0;
          SENSE_ANY: extTrig[gi] = primed && (extSync2[gi] != extPrev[gi]);
          SENSE_FALL: extTrig[gi] = primed && extPrev[gi] && !extSync2[gi];
          SENSE_RISE: extTrig[gi] = primed && !extPrev[gi] && extSync2[gi];
        endcase
      end
    end
  endgenerate

  // group change detect, only unmasked inputs count
  assign grpTrig[0] = primed && |((chgNow[7:0] ^ chgPast[7:0]) & chgMask[7:0]); // R13
  assign grpTrig[1] = primed && |((chgNow[15:8] ^ chgPast[15:8]) & chgMask[15:8]); // R13

  assign extClrW = (regWrite && regAddr == ADDR_EXT_FLAGS) ? regWrData[1:0] : 2'h0; // R9
  assign grpClrW = (regWrite && regAddr == ADDR_GRP_FLAGS) ? regWrData[1:0] : 2'h0; // R9
  assign extClrV[0] = vectorAck && vectorNum == VEC_PIN_ZERO; // R8
  assign extClrV[1] = vectorAck && vectorNum == VEC_PIN_ONE; // R8
  assign grpClrV[0] = vectorAck && vectorNum == VEC_GROUP_LO; // R8
  assign grpClrV[1] = vectorAck && vectorNum == VEC_GROUP_HI; // R8

  // flags: a trigger in the clearing cycle wins so no event is lost
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ext_irq_flags <= 2'h0;
    end else begin
      ext_irq_flags <= ((ext_irq_flags & ~extClrW & ~extClrV) | extTrig) & ~extLevelMode; // R5 R6
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      change_group_flags <= 2'h0;
    end else begin
      change_group_flags <= (change_group_flags & ~grpClrW & ~grpClrV) | grpTrig; // R12
    end
  end

  // software registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sense_control_reg <= 4'h0;
      ext_irq_enable <= 2'h0;
      change_group_enable <= 2'h0;
      change_mask_high <= RESET_BYTE;
      change_mask_low <= RESET_BYTE;
      globalEnable <= 1'b0;
      irqMask <= 4'h0;
    end else if (regWrite) begin
      unique case (regAddr)
        ADDR_SENSE: sense_control_reg <= regWrData[3:0];
        ADDR_EXT_EN: ext_irq_enable <= regWrData[1:0];
        ADDR_GRP_EN: change_group_enable <= regWrData[1:0];
        ADDR_MASK_HI: change_mask_high <= regWrData;
        ADDR_MASK_LO: change_mask_low <= regWrData;
        ADDR_CORE: globalEnable <= regWrData[CORE_GIE_BIT];
        ADDR_IRQ_MASK: irqMask <= regWrData[3:0];
        default: ;
      endcase
    end
  end

  // pending sources; level mode presents the pin directly
  assign extPend = (ext_irq_flags | extLevel) & ext_irq_enable & {2{globalEnable}}; // R1 R7
  assign grpPend = change_group_flags & change_group_enable & {2{globalEnable}}; // R11 R7

  // fixed priority: pin zero, pin one, group lo, group hi
  always_comb begin
    if (extPend[0]) begin
      next_vectorNum = VEC_PIN_ZERO; // R10
    end else if (extPend[1]) begin
      next_vectorNum = VEC_PIN_ONE; // R10
    end else if (grpPend[0]) begin
      next_vectorNum = VEC_GROUP_LO; // R10
    end else if (grpPend[1]) begin
      next_vectorNum = VEC_GROUP_HI; // R10
    end else begin
      next_vectorNum = VEC_NONE;
    end
  end

  // registered vector; ack taken as entry into the routine
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      vectorNum <= VEC_NONE;
    end else if (vectorAck) begin
      vectorNum <= VEC_NONE;
    end else begin
      vectorNum <= next_vectorNum; // R7
    end
  end

  assign vectorReq = (vectorNum != VEC_NONE);

  // sticky event status for the summary interrupt, write one to clear, set wins
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irqStatus <= 4'h0;
    end else begin
      irqStatus <= (irqStatus & ~((regWrite && regAddr == ADDR_IRQ_STAT) ? regWrData[3:0] : 4'h0))
        | {grpTrig[1], grpTrig[0], extTrig[1] | extLevel[1], extTrig[0] | extLevel[0]};
    end
  end

  assign irq = |(irqStatus & irqMask);

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_SENSE: regRdData <= {4'h0, sense_control_reg};
        ADDR_EXT_EN: regRdData <= {6'h00, ext_irq_enable}; // R14
        ADDR_EXT_FLAGS: regRdData <= {6'h00, ext_irq_flags}; // R14
        ADDR_GRP_EN: regRdData <= {6'h00, change_group_enable}; // R14
        ADDR_GRP_FLAGS: regRdData <= {6'h00, change_group_flags}; // R14
        ADDR_MASK_HI: regRdData <= change_mask_high;
        ADDR_MASK_LO: regRdData <= change_mask_low;
        ADDR_CORE: regRdData <= {globalEnable, 7'h00};
        ADDR_IRQ_STAT: regRdData <= {4'h0, irqStatus};
        ADDR_IRQ_MASK: regRdData <= {4'h0, irqMask};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule

// [hdl/epiu_pkg.sv]
// package for the external pin interrupt unit: register map, field layout, vectors
package epiu_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_SENSE = 4'h0;
  localparam logic [3:0] ADDR_EXT_EN = 4'h1;
  localparam logic [3:0] ADDR_EXT_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_GRP_EN = 4'h3;
  localparam logic [3:0] ADDR_GRP_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_MASK_HI = 4'h5;
  localparam logic [3:0] ADDR_MASK_LO = 4'h6;
  localparam logic [3:0] ADDR_CORE = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int CORE_GIE_BIT = 7;
  localparam int SENSE_ONE_POS = 2;
  localparam int SENSE_ZERO_POS = 0;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  localparam logic [2:0] VEC_NONE = 3'h0;
  localparam logic [2:0] VEC_PIN_ZERO = 3'h1;
  localparam logic [2:0] VEC_PIN_ONE = 3'h2;
  localparam logic [2:0] VEC_GROUP_LO = 3'h3;
  localparam logic [2:0] VEC_GROUP_HI = 3'h4;
endpackage
